// ==== design/fiwb_buffer.sv ====
// Page-sized write buffer with per-word store and whole clear
module fiwb_buffer #(
   parameter int WORDS = 64,
   parameter int AW    = 6
) (
   input  wire logic          pclk,
   input  wire logic          presetn,
   input  wire logic          load,
   input  wire logic [AW-1:0] load_idx,
   input  wire logic [15:0]   load_word,
   input  wire logic          clear,
   input  wire logic [AW-1:0] rd_idx,
   output logic      [15:0]   rd_word
);
   logic [15:0] mem_q [WORDS];

   // One generate entry per buffer word, cleared as a whole
   for (genvar i = 0; i < WORDS; i++) begin : g_word
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            mem_q[i] <= 16'h0000;
         end else if (clear) begin
            mem_q[i] <= 16'h0000;
         end else if (load && load_idx == AW'(i)) begin
            mem_q[i] <= load_word;
         end
      end
   end

   assign rd_word = mem_q[rd_idx];

   // Checks: word store, and clear of the first and last words
   load_store_a: assert property (@(posedge pclk) disable iff (!presetn)
      (load && !clear) |=> mem_q[$past(load_idx)] == $past(load_word))
      else $error("buffer word not stored");
   buf_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      clear |=> mem_q[0] == 16'h0000 && mem_q[WORDS-1] == 16'h0000)
      else $error("buffer not cleared");
endmodule

// ==== design/fiwb_ctrl.sv ====
// Flash in-application programming controller with page write buffer
//
// Implementation choices: the APB slave port and the placing of the registers.
`include "fiwb_map.svh"
module fiwb_ctrl #(
   parameter int PAGE_WORDS = 64,
   parameter int ADDR_BITS  = 15
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             busy
);
   localparam int PB = $clog2(PAGE_WORDS);
   localparam int WR_CYC = (`FIWB_WR_TIME_NS + `FIWB_CLK_NS - 1) / `FIWB_CLK_NS;
   localparam int ER_CYC = (`FIWB_ER_TIME_NS + `FIWB_CLK_NS - 1) / `FIWB_CLK_NS;
   localparam int RD_CYC = (`FIWB_RD_TIME_NS + `FIWB_CLK_NS - 1) / `FIWB_CLK_NS;
   localparam logic [PB-1:0] LAST = {PB{1'b1}};

   fiwb_pkg::fiwb_state_t state_q;
   logic [7:0]  ctrl_main_q;
   logic [7:0]  ctrl_second_q;
   logic [7:0]  addr_low_q;
   logic [7:0]  addr_high_q;
   logic [7:0]  dlo_q [4];
   logic [7:0]  dhi_q [4];
   logic        clr_q;
   logic [11:0] cnt_q;
   logic [PB:0] idx_q;

   // APB decode, one cycle access
   wire         wr_acc  = psel && penable && pwrite;
   wire         rd_acc  = psel && penable && !pwrite;
   wire [7:0]   wb      = pwdata[7:0];
   wire         hit_cm  = paddr == `FIWB_OFS_CTRL_MAIN;
   wire         hit_c2  = paddr == `FIWB_OFS_CTRL_SECOND;
   wire         hit_c3  = paddr == `FIWB_OFS_CTRL_THIRD;
   wire         hit_al  = paddr == `FIWB_OFS_ADDR_LOW;
   wire         hit_ah  = paddr == `FIWB_OFS_ADDR_HIGH;
   wire         hit_d0h = paddr == `FIWB_OFS_DATA0_HIGH;
   wire [1:0]   dsel    = 2'((paddr - `FIWB_OFS_DATA0_LOW) >> 3);
   wire         d_hit   = paddr >= `FIWB_OFS_DATA0_LOW && paddr <= `FIWB_OFS_DATA3_HIGH && paddr[1:0] == 2'b00;
   wire         d_is_hi = paddr[2] == 1'b0;
   wire         mapped  = hit_cm || hit_c2 || hit_c3 || hit_al || hit_ah || d_hit;
   wire [2:0]   mode    = ctrl_main_q[`FIWB_BIT_MODE_HI:`FIWB_BIT_MODE_LO];
   wire         ew_en   = ctrl_main_q[`FIWB_BIT_EW_EN];
   wire         idle    = state_q == fiwb_pkg::FIWB_IDLE;

   // Flash word address from high and low address registers
   wire [ADDR_BITS-1:0] faddr = ADDR_BITS'({addr_high_q, addr_low_q});
   wire [PB-1:0]        in_pg = faddr[PB-1:0];
   wire [ADDR_BITS-PB-1:0] page = faddr[ADDR_BITS-1:PB];
   // High byte joins the load from the bus, its register updates on the same edge
   wire                 load  = wr_acc && hit_d0h && ew_en;
   wire [ADDR_BITS-1:0] f_next = (in_pg == LAST) ? faddr : faddr + ADDR_BITS'(1);

   // Operation sequencing
   wire start_wr  = idle && ctrl_main_q[`FIWB_BIT_WR_START] && ew_en && mode == `FIWB_MODE_WRITE;
   wire start_er  = idle && ctrl_main_q[`FIWB_BIT_WR_START] && ew_en && mode == `FIWB_MODE_ERASE;
   wire start_rd  = idle && ctrl_main_q[`FIWB_BIT_RD_START] && ctrl_main_q[`FIWB_BIT_RD_EN]
                    && mode == `FIWB_MODE_READ;
   wire start_clr = idle && clr_q;
   wire done_wr   = state_q == fiwb_pkg::FIWB_WRITE && idx_q == (PB+1)'(PAGE_WORDS) && cnt_q == 12'h000;
   wire done_er   = state_q == fiwb_pkg::FIWB_ERASE && idx_q == (PB+1)'(PAGE_WORDS) && cnt_q == 12'h000;
   wire done_rd   = state_q == fiwb_pkg::FIWB_READ && cnt_q == 12'h000;
   wire done_clr  = state_q == fiwb_pkg::FIWB_CLEAR;
   wire arr_we    = (state_q == fiwb_pkg::FIWB_WRITE || state_q == fiwb_pkg::FIWB_ERASE)
                    && idx_q < (PB+1)'(PAGE_WORDS);
   wire [PB-1:0] idx_w = idx_q[PB-1:0];

   logic [15:0] buf_word;
   logic [15:0] arr_word;
   wire  [15:0] arr_wdata = (state_q == fiwb_pkg::FIWB_ERASE) ? 16'hFFFF : buf_word;
   wire  [ADDR_BITS-1:0] arr_waddr = {page, idx_w};
   wire  ew_unlock = wr_acc && hit_cm && wb[`FIWB_BIT_MODE_HI:`FIWB_BIT_MODE_LO] == `FIWB_MODE_EW_ENABLE
                     && wb[`FIWB_BIT_PROT_EN];

   fiwb_buffer #(.WORDS(PAGE_WORDS), .AW(PB)) u_buf (
      .pclk      (pclk),
      .presetn   (presetn),
      .load      (load),
      .load_idx  (in_pg),
      .load_word ({wb, dlo_q[0]}),
      .clear     (done_clr || done_wr),
      .rd_idx    (idx_w),
      .rd_word   (buf_word)
   );

   fiwb_flash_array #(.DEPTH(1 << ADDR_BITS), .AW(ADDR_BITS)) u_arr (
      .pclk  (pclk),
      .we    (arr_we),
      .waddr (arr_waddr),
      .wdata (arr_wdata),
      .raddr (faddr),
      .rdata (arr_word)
   );

   // Sequencer state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= fiwb_pkg::FIWB_IDLE;
         cnt_q   <= 12'h000;
         idx_q   <= '0;
      end else begin
         case (state_q)
            fiwb_pkg::FIWB_IDLE: begin
               idx_q <= '0;
               if (start_clr) begin
                  state_q <= fiwb_pkg::FIWB_CLEAR;
               end else if (start_wr) begin
                  state_q <= fiwb_pkg::FIWB_WRITE;
                  cnt_q   <= 12'(WR_CYC);
               end else if (start_er) begin
                  state_q <= fiwb_pkg::FIWB_ERASE;
                  cnt_q   <= 12'(ER_CYC);
               end else if (start_rd) begin
                  state_q <= fiwb_pkg::FIWB_READ;
                  cnt_q   <= 12'(RD_CYC);
               end
            end
            fiwb_pkg::FIWB_WRITE, fiwb_pkg::FIWB_ERASE: begin
               if (idx_q < (PB+1)'(PAGE_WORDS)) begin
                  idx_q <= idx_q + (PB+1)'(1);
               end else if (cnt_q != 12'h000) begin
                  cnt_q <= cnt_q - 12'h001;
               end else begin
                  state_q <= fiwb_pkg::FIWB_IDLE;
               end
            end
            fiwb_pkg::FIWB_READ: begin
               if (cnt_q != 12'h000) begin
                  cnt_q <= cnt_q - 12'h001;
               end else begin
                  state_q <= fiwb_pkg::FIWB_IDLE;
               end
            end
            default: state_q <= fiwb_pkg::FIWB_IDLE;
         endcase
      end
   end

   // Main control register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_main_q <= `FIWB_RST_BYTE;
      end else begin
         if (wr_acc && hit_cm) begin
            // Software may clear the enabled flag; writing it as one never sets it, only the unlock write (ew_unlock) does
            ctrl_main_q[6:0] <= wb[6:0];
            if (!wb[`FIWB_BIT_EW_EN]) ctrl_main_q[`FIWB_BIT_EW_EN] <= 1'b0;
            // Busy flags cannot be dropped by software mid-operation
            if (!idle) ctrl_main_q[`FIWB_BIT_WR_START] <= ctrl_main_q[`FIWB_BIT_WR_START];
            if (!idle) ctrl_main_q[`FIWB_BIT_RD_START] <= ctrl_main_q[`FIWB_BIT_RD_START];
         end
         if (ew_unlock) ctrl_main_q[`FIWB_BIT_EW_EN] <= 1'b1;
         if (done_wr || done_er) ctrl_main_q[`FIWB_BIT_WR_START] <= 1'b0;
         if (done_rd) ctrl_main_q[`FIWB_BIT_RD_START] <= 1'b0;
      end
   end

   // Second and third control, address and data registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_second_q <= `FIWB_RST_BYTE;
         clr_q         <= 1'b0;
         addr_low_q    <= `FIWB_RST_BYTE;
         addr_high_q   <= `FIWB_RST_BYTE;
         for (int i = 0; i < 4; i++) begin
            dlo_q[i] <= `FIWB_RST_BYTE;
            dhi_q[i] <= `FIWB_RST_BYTE;
         end
      end else begin
         if (wr_acc && hit_c2) ctrl_second_q <= wb;
         if (wr_acc && hit_c3 && wb[`FIWB_BIT_CLR_BUF]) begin
            clr_q <= 1'b1;
         end else if (done_clr) begin
            clr_q <= 1'b0;
         end
         if (wr_acc && hit_al) addr_low_q <= wb;
         if (wr_acc && hit_ah) addr_high_q <= 8'(wb[ADDR_BITS-9:0]);
         if (load) begin
            {addr_high_q, addr_low_q} <= 16'(f_next);
         end
         if (wr_acc && d_hit && !d_is_hi) dlo_q[dsel] <= wb;
         if (wr_acc && d_hit && d_is_hi) dhi_q[dsel] <= wb;
         if (done_rd) begin
            dlo_q[0] <= arr_word[7:0];
            dhi_q[0] <= arr_word[15:8];
         end
      end
   end

   // Read data and bus answer
   always_comb begin
      prdata = 32'h0000_0000;
      if (rd_acc) begin
         if (hit_cm) prdata[7:0] = ctrl_main_q;
         else if (hit_c2) prdata[7:0] = ctrl_second_q;
         else if (hit_c3) prdata[7:0] = {7'h00, clr_q};
         else if (hit_al) prdata[7:0] = addr_low_q;
         else if (hit_ah) prdata[7:0] = addr_high_q;
         else if (d_hit) prdata[7:0] = d_is_hi ? dhi_q[dsel] : dlo_q[dsel];
      end
   end
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign busy    = !idle;

   // Checks: enabled flag
   enable_set_a: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(ew_en) |-> $past(ew_unlock))
      else $error("enable flag set without procedure");
   sw_set_a: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_acc && hit_cm && wb[`FIWB_BIT_EW_EN] && !ew_unlock && !ew_en) |=> !ew_en)
      else $error("software raised enable flag");
   sw_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_acc && hit_cm && !wb[`FIWB_BIT_EW_EN] && !ew_unlock) |=> !ew_en)
      else $error("enable flag not cleared");

   // Checks: buffer loads and address stepping
   load_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_acc && hit_d0h && !ew_en && !hit_al && !hit_ah) |=> $stable({addr_high_q, addr_low_q}))
      else $error("address moved while disabled");
   low_only_a: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_acc && d_hit && !d_is_hi) |=> $stable({addr_high_q, addr_low_q}))
      else $error("low byte write moved address");
   addr_inc_a: assert property (@(posedge pclk) disable iff (!presetn)
      (load && in_pg != LAST) |=> faddr == $past(faddr) + ADDR_BITS'(1))
      else $error("no increment");
   addr_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
      (load && in_pg == LAST) |=> faddr == $past(faddr))
      else $error("passed page end");

   // Checks: start flags, busy and read result
   busy_start_a: assert property (@(posedge pclk) disable iff (!presetn)
      (start_wr || start_er) |=> busy)
      else $error("busy not raised on start");
   wr_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      done_wr |=> !ctrl_main_q[`FIWB_BIT_WR_START])
      else $error("write flag stuck");
   busy_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
      state_q == fiwb_pkg::FIWB_WRITE |-> ctrl_main_q[`FIWB_BIT_WR_START])
      else $error("busy not shown");
   rd_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      start_rd |=> ##[1:4] !ctrl_main_q[`FIWB_BIT_RD_START])
      else $error("read flag stuck");
   rd_word_a: assert property (@(posedge pclk) disable iff (!presetn)
      done_rd |=> {dhi_q[0], dlo_q[0]} == $past(arr_word))
      else $error("read word not delivered");

   // Checks: buffer clear flag
   clr_set_a: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_acc && hit_c3 && wb[`FIWB_BIT_CLR_BUF]) |=> clr_q)
      else $error("clear flag not set");
   clr_done_a: assert property (@(posedge pclk) disable iff (!presetn)
      start_clr |=> ##1 !clr_q)
      else $error("clear flag stuck");
endmodule

// ==== design/fiwb_flash_array.sv ====
// Behavioural program memory: page program, page erase, word read
module fiwb_flash_array #(
   parameter int DEPTH = 32768,
   parameter int AW    = 15
) (
   input  wire logic          pclk,
   input  wire logic          we,
   input  wire logic [AW-1:0] waddr,
   input  wire logic [15:0]   wdata,
   input  wire logic [AW-1:0] raddr,
   output logic      [15:0]   rdata
);
   logic [15:0] mem [DEPTH];

   // Erase writes all ones; program writes buffer words
   always_ff @(posedge pclk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule

// ==== design/fiwb_map.svh ====
// Register offsets, field positions, reset values and operation times
`ifndef FIWB_MAP_SVH
`define FIWB_MAP_SVH
// Byte offsets on APB (printed order kept, one word each)
`define FIWB_OFS_CTRL_MAIN   12'h000
`define FIWB_OFS_CTRL_SECOND 12'h004
`define FIWB_OFS_CTRL_THIRD  12'h008
`define FIWB_OFS_ADDR_LOW    12'h00C
`define FIWB_OFS_ADDR_HIGH   12'h010
`define FIWB_OFS_DATA0_LOW   12'h014
`define FIWB_OFS_DATA0_HIGH  12'h018
`define FIWB_OFS_DATA1_LOW   12'h01C
`define FIWB_OFS_DATA1_HIGH  12'h020
`define FIWB_OFS_DATA2_LOW   12'h024
`define FIWB_OFS_DATA2_HIGH  12'h028
`define FIWB_OFS_DATA3_LOW   12'h02C
`define FIWB_OFS_DATA3_HIGH  12'h030
// Main control field positions, plus the buffer clear bit of the third control
`define FIWB_BIT_EW_EN       7
`define FIWB_BIT_MODE_HI     6
`define FIWB_BIT_MODE_LO     4
`define FIWB_BIT_PROT_EN     3
`define FIWB_BIT_WR_START    2
`define FIWB_BIT_RD_EN       1
`define FIWB_BIT_RD_START    0
`define FIWB_BIT_CLR_BUF     0
// Mode codes
`define FIWB_MODE_WRITE      3'h0
`define FIWB_MODE_ERASE      3'h1
`define FIWB_MODE_READ       3'h3
`define FIWB_MODE_EW_ENABLE  3'h6
// Reset value of every register
`define FIWB_RST_BYTE        8'h00
// Operation times in ns, clock period 50 ns (20 MHz)
`define FIWB_CLK_NS          50
`define FIWB_WR_TIME_NS      2000
`define FIWB_ER_TIME_NS      2000
`define FIWB_RD_TIME_NS      100
`endif

// ==== design/fiwb_pkg.sv ====
// Types shared by the flash write buffer controller
package fiwb_pkg;
   typedef enum logic [2:0] {
      FIWB_IDLE,
      FIWB_WRITE,
      FIWB_ERASE,
      FIWB_READ,
      FIWB_CLEAR
   } fiwb_state_t;
endpackage

// ==== tb/tb_fiwb_ctrl.sv ====
// Self-checking testbench for the flash write buffer controller
`include "fiwb_map.svh"
module tb_fiwb_ctrl;
   timeunit 1ns;
   timeprecision 1ps;
   logic        pclk     = 1'h0;
   logic        presetn  = 1'h0;
   logic        psel     = 1'h0;
   logic        penable  = 1'h0;
   logic        pwrite   = 1'h0;
   logic [11:0] paddr    = 12'h000;
   logic [31:0] pwdata   = 32'h0000_0000;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        busy;
   logic [31:0] rd;
   logic        err;
   int          mismatches  = 0;
   int          checks_done = 0;
   int          cycles      = 0;

   // Small page variant so the boundary is reached quickly
   fiwb_ctrl #(
      .PAGE_WORDS (32),
      .ADDR_BITS  (13)
   ) DUT (
      .pclk    (pclk),
      .presetn (presetn),
      .psel    (psel),
      .penable (penable),
      .pwrite  (pwrite),
      .paddr   (paddr),
      .pwdata  (pwdata),
      .prdata  (prdata),
      .pready  (pready),
      .pslverr (pslverr),
      .busy    (busy)
   );

   // Clock, 50 ns period
   initial begin
      forever #25 pclk = ~pclk;
   end

   // Hang guard
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 4000) begin
         mismatches++;
         end_of_test();
      end
   end

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // One APB transfer; holds the request until pready is seen high
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      @(posedge pclk);
      psel   <= 1'h1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'h1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'h1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'h0;
      penable <= 1'h0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      apb(1'h1, a, d);
   endtask

   task automatic rdm(input string name, input logic [11:0] a, input logic [7:0] m, input logic [7:0] exp);
      apb(1'h0, a, 8'h00);
      check(name, rd & {24'h000000, m}, {24'h000000, exp});
   endtask

   // Reads until the masked bits drop, bounded
   task automatic poll(input string name, input logic [11:0] a, input logic [7:0] m);
      int k;
      k = 0;
      do begin
         apb(1'h0, a, 8'h00);
         k++;
      end while ((rd[7:0] & m) !== 8'h00 && k < 100);
      check(name, {24'h000000, rd[7:0] & m}, 32'h0000_0000);
   endtask

   // Reads one flash word of the current page and compares both bytes
   task automatic flash_read(input logic [7:0] a, input logic [7:0] lo, input logic [7:0] hi);
      wr(`FIWB_OFS_ADDR_LOW, a);
      wr(`FIWB_OFS_CTRL_MAIN, {1'h1, `FIWB_MODE_READ, 4'h3});
      poll("read done", `FIWB_OFS_CTRL_MAIN, 8'h01);
      rdm("read low byte", `FIWB_OFS_DATA0_LOW, 8'hFF, lo);
      rdm("read high byte", `FIWB_OFS_DATA0_HIGH, 8'hFF, hi);
   endtask

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'h1;
      rdm("ctrl_main reset", `FIWB_OFS_CTRL_MAIN, 8'hFF, 8'h00);
      rdm("ctrl_third reset", `FIWB_OFS_CTRL_THIRD, 8'hFF, 8'h00);
      rdm("addr_low reset", `FIWB_OFS_ADDR_LOW, 8'hFF, 8'h00);
      rdm("data3_high reset", `FIWB_OFS_DATA3_HIGH, 8'hFF, 8'h00);
      apb(1'h0, 12'h040, 8'h00);
      check("unmapped error", {31'h00000000, err}, 32'h0000_0001);
      check("unmapped data", rd, 32'h0000_0000);
      $display("test reset done");
      // Software cannot raise the enabled flag; loads refused while low
      wr(`FIWB_OFS_CTRL_MAIN, 8'h80);
      rdm("enabled set by sw", `FIWB_OFS_CTRL_MAIN, 8'h80, 8'h00);
      wr(`FIWB_OFS_ADDR_LOW, 8'h45);
      wr(`FIWB_OFS_DATA0_HIGH, 8'h11);
      rdm("addr while off", `FIWB_OFS_ADDR_LOW, 8'hFF, 8'h45);
      rdm("data0_high stored", `FIWB_OFS_DATA0_HIGH, 8'hFF, 8'h11);
      $display("test disabled done");
      wr(`FIWB_OFS_CTRL_MAIN, {1'h0, `FIWB_MODE_EW_ENABLE, 4'h8});
      rdm("enabled by procedure", `FIWB_OFS_CTRL_MAIN, 8'h80, 8'h80);
      // Erase page 2, low bits of the address ignored
      wr(`FIWB_OFS_ADDR_HIGH, 8'h00);
      wr(`FIWB_OFS_ADDR_LOW, 8'h47);
      wr(`FIWB_OFS_CTRL_MAIN, {1'h1, `FIWB_MODE_ERASE, 4'h4});
      poll("erase done", `FIWB_OFS_CTRL_MAIN, 8'h04);
      flash_read(8'h41, 8'hFF, 8'hFF);
      flash_read(8'h5F, 8'hFF, 8'hFF);
      wr(`FIWB_OFS_CTRL_THIRD, 8'h01);
      poll("clear buffer done", `FIWB_OFS_CTRL_THIRD, 8'h01);
      $display("test erase done");
      // Load the last two words of the page and hit the boundary
      wr(`FIWB_OFS_ADDR_LOW, 8'h5E);
      wr(`FIWB_OFS_DATA0_LOW, 8'hC3);
      rdm("addr after low", `FIWB_OFS_ADDR_LOW, 8'hFF, 8'h5E);
      wr(`FIWB_OFS_DATA0_HIGH, 8'hA5);
      rdm("addr after load", `FIWB_OFS_ADDR_LOW, 8'hFF, 8'h5F);
      wr(`FIWB_OFS_DATA0_HIGH, 8'hA5);
      rdm("addr at boundary", `FIWB_OFS_ADDR_LOW, 8'hFF, 8'h5F);
      rdm("addr_high at boundary", `FIWB_OFS_ADDR_HIGH, 8'hFF, 8'h00);
      $display("test load done");
      // Page write with busy indication, page address given again after the boundary
      wr(`FIWB_OFS_ADDR_LOW, 8'h40);
      wr(`FIWB_OFS_CTRL_MAIN, {1'h1, `FIWB_MODE_WRITE, 4'h4});
      repeat (2) @(negedge pclk);
      check("busy during write", {31'h00000000, busy}, 32'h0000_0001);
      poll("write done", `FIWB_OFS_CTRL_MAIN, 8'h04);
      check("busy after write", {31'h00000000, busy}, 32'h0000_0000);
      $display("test write done");
      // Read back both loaded words
      flash_read(8'h5E, 8'hC3, 8'hA5);
      flash_read(8'h5F, 8'hC3, 8'hA5);
      $display("test read done");
      // A write with no new loads programs the page to all zeros once the buffer self-clears
      wr(`FIWB_OFS_CTRL_MAIN, {1'h1, `FIWB_MODE_ERASE, 4'h4});
      poll("erase again done", `FIWB_OFS_CTRL_MAIN, 8'h04);
      wr(`FIWB_OFS_CTRL_MAIN, {1'h1, `FIWB_MODE_WRITE, 4'h4});
      poll("empty write done", `FIWB_OFS_CTRL_MAIN, 8'h04);
      flash_read(8'h5E, 8'h00, 8'h00);
      $display("test auto clear done");
      // Manual clear and reload before a repeated write
      wr(`FIWB_OFS_CTRL_THIRD, 8'h01);
      poll("manual clear done", `FIWB_OFS_CTRL_THIRD, 8'h01);
      wr(`FIWB_OFS_ADDR_LOW, 8'h40);
      wr(`FIWB_OFS_DATA0_LOW, 8'h3C);
      wr(`FIWB_OFS_DATA0_HIGH, 8'h5A);
      wr(`FIWB_OFS_CTRL_MAIN, {1'h1, `FIWB_MODE_ERASE, 4'h4});
      poll("erase third done", `FIWB_OFS_CTRL_MAIN, 8'h04);
      wr(`FIWB_OFS_CTRL_MAIN, {1'h1, `FIWB_MODE_WRITE, 4'h4});
      poll("rewrite done", `FIWB_OFS_CTRL_MAIN, 8'h04);
      flash_read(8'h40, 8'h3C, 8'h5A);
      $display("test reload done");
      wr(`FIWB_OFS_CTRL_MAIN, 8'h00);
      rdm("enabled cleared by sw", `FIWB_OFS_CTRL_MAIN, 8'h80, 8'h00);
      $display("test disable done");
      end_of_test();
   end
endmodule
